// ==== core/fieldbus_slave.sv ====
// fieldbus slave i/o processing: data and parameter ports, filters, sync i/o, watchdogs
// assumes an upstream receiver that delivers decoded calls as one-cycle pulses on tel_*
// and an encoder whose manchester output arrives on aux_tx_code; registers over axi4-lite
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
module fieldbus_slave #(
  parameter int FILTER_BASE_CYC = fieldbus_slave_pkg::FILTER_BASE_CYC,
  parameter int HALF_WD_CYC = fieldbus_slave_pkg::HALF_WD_CYC,
  parameter int COMM_MON_CYC = fieldbus_slave_pkg::COMM_MON_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite register bus
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // decoded calls and reply
  input wire logic tel_valid,
  input wire logic [2:0] tel_kind,
  input wire logic [4:0] tel_addr,
  input wire logic [4:0] tel_info,
  input wire logic tel_to_me,
  output logic resp_valid,
  output logic [3:0] resp_info,
  output logic prog_mode_req,
  // auxiliary addressing channel
  input wire logic aux_addressing_input_cmos,
  input wire logic aux_addressing_input_photo,
  input wire logic magic_seq_seen,
  input wire logic aux_tx_code,
  output logic aux_rx_data,
  output logic status_lamp_one,
  // data port
  input wire logic [3:0] data_in,
  output logic [3:0] data_out,
  output logic data_out_en,
  output logic data_strobe,
  // parameter port
  input wire logic [3:0] param_in,
  output logic [3:0] param_out,
  output logic param_oe_n,
  output logic param_strobe
);
  typedef struct packed {
    logic awready;
    logic wready;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [31:0] cfg;
    logic [15:0] iocfg;
    logic init;
    logic slave_active;
    logic aux_active;
    logic aux_cmos;
    logic cmos_q;
    logic photo_q;
    logic aux_rx;
    logic lamp;
    fieldbus_slave_pkg::seq_t seq;
    logic [7:0] win_cnt;
    logic [3:0] data_out;
    logic data_en;
    logic data_strobe;
    logic [3:0] param_out;
    logic param_oe_n;
    logic param_strobe;
    logic [3:0] send_reg;
    logic resp_valid;
    logic [3:0] resp_info;
    logic [3:0] pend_out;
    logic pend_valid;
    logic [4:0] last_addr;
    logic [31:0] cyc_cnt;
    logic [31:0] cyc_meas;
    logic prev_half;
    logic [31:0] half_cnt;
    logic half_exp;
    logic [31:0] mon_cnt;
    logic no_exch;
    logic soft_rst;
    logic [3:0] id1;
    logic prog_req;
  } state_t;
  state_t s_reg;
  state_t s_next;
  logic [3:0] filt;
  logic [3:0] filt_mask;
  logic [31:0] filt_dur;
  logic filt_on;

  // reset image: bus ready, ports driven low, init pending
  function automatic state_t reset_state();
    state_t r;
    r = '0;
    r.awready = 1'b1;
    r.wready = 1'b1;
    r.arready = 1'b1;
    r.cfg = fieldbus_slave_pkg::CFG_RESET;
    r.iocfg = fieldbus_slave_pkg::IOCFG_RESET;
    r.init = 1'b1;
    r.data_en = 1'b1;
    r.seq = fieldbus_slave_pkg::IDLE;
    return r;
  endfunction

  // byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++)
      if (strb[b])
        m[b*8 +: 8] = nw[b*8 +: 8];
    return m;
  endfunction

  // fixed levels override the selected output bits
  function automatic logic [3:0] fixed(input logic [3:0] d, input logic [15:0] io);
    logic [3:0] msk;
    msk = io[fieldbus_slave_pkg::IOCFG_FIXED_MASK +: 4];
    return (d & ~msk) | (io[fieldbus_slave_pkg::IOCFG_FIXED_LEVEL +: 4] & msk);
  endfunction

  // new output nibble from a data request
  function automatic logic [3:0] next_out(input logic [4:0] info, input logic [3:0] old, input logic [31:0] c);
    logic [3:0] o;
    o = info[3:0];
    if (c[fieldbus_slave_pkg::CFG_EXT_ADDR])
    begin
      o = {old[3], info[2:0]};
      if (c[fieldbus_slave_pkg::CFG_EXT_FOUR_OUT])
        o = info[fieldbus_slave_pkg::HALF_SEL_BIT] ? {info[1:0], old[1:0]} : {old[3:2], info[1:0]};
    end
    return o;
  endfunction

  // filter control; safety mode keeps the delaying path out
  always_comb
  begin
    filt_on = (s_reg.cfg[fieldbus_slave_pkg::CFG_FILTER_EN]
      || (s_reg.cfg[fieldbus_slave_pkg::CFG_FILTER_P2] && s_reg.param_out[2]))
      && !s_reg.cfg[fieldbus_slave_pkg::CFG_SAFETY];
    filt_mask = filt_on ? s_reg.iocfg[fieldbus_slave_pkg::IOCFG_FILTER +: 4] : 4'h0;
    if (s_reg.cfg[fieldbus_slave_pkg::CFG_FILTER_SEL +: 3] == 3'h0)
      filt_mask = 4'h0;
    filt_dur = 32'(FILTER_BASE_CYC) << (s_reg.cfg[fieldbus_slave_pkg::CFG_FILTER_SEL +: 3] - 3'h1);
    if (s_reg.cfg[fieldbus_slave_pkg::CFG_CYCLE_MODE] && s_reg.cyc_meas != 32'h0000_0000)
      filt_dur = s_reg.cyc_meas;
  end

  input_debounce #(
    .W(4)
  ) u_debounce (
    .aclk(aclk),
    .rst_n(aresetn && !s_reg.soft_rst),
    .enable(filt_mask),
    .duration(filt_dur),
    .raw(data_in),
    .filt(filt)
  );

  // next-state logic
  always_comb
  begin
    logic mine;
    logic sync_on;
    logic sync_evt;
    logic wd_on;
    logic pend_now;
    logic [3:0] pend_val;
    logic [3:0] sampled;
    s_next = s_reg;
    mine = tel_valid && tel_to_me && s_reg.slave_active && s_reg.seq == fieldbus_slave_pkg::IDLE;
    sync_on = s_reg.cfg[fieldbus_slave_pkg::CFG_SYNC_MODE] && !s_reg.cfg[fieldbus_slave_pkg::CFG_SAFETY];
    sync_evt = tel_valid && tel_kind == fieldbus_slave_pkg::KIND_DATA && tel_addr < s_reg.last_addr;
    wd_on = s_reg.cfg[fieldbus_slave_pkg::CFG_COMM_WD_EN]
      && (!s_reg.cfg[fieldbus_slave_pkg::CFG_COMM_WD_P0] || s_reg.param_out[0]);
    sampled = filt ^ (s_reg.cfg[fieldbus_slave_pkg::CFG_INVERT_ALL] ? 4'hF
      : s_reg.iocfg[fieldbus_slave_pkg::IOCFG_INVERT +: 4]);
    pend_now = s_reg.pend_valid;
    pend_val = s_reg.pend_out;
    s_next.resp_valid = 1'b0;
    s_next.prog_req = 1'b0;
    s_next.soft_rst = 1'b0;
    s_next.init = 1'b0;

    // axi write: address and data in either order, answer once both are held
    if (awvalid && s_reg.awready)
    begin
      s_next.awaddr = awaddr;
      s_next.awready = 1'b0;
    end
    if (wvalid && s_reg.wready)
    begin
      s_next.wdata = wdata;
      s_next.wstrb = wstrb;
      s_next.wready = 1'b0;
    end
    if (!s_reg.awready && !s_reg.wready && !s_reg.bvalid)
    begin
      s_next.bvalid = 1'b1;
      s_next.bresp = fieldbus_slave_pkg::RESP_OKAY;
      if (s_reg.awaddr == fieldbus_slave_pkg::CFG_OFFS)
        s_next.cfg = merge(s_reg.cfg, s_reg.wdata, s_reg.wstrb);
      else if (s_reg.awaddr == fieldbus_slave_pkg::IOCFG_OFFS)
        s_next.iocfg = 16'(merge({16'h0000, s_reg.iocfg}, s_reg.wdata, s_reg.wstrb));
      else
        s_next.bresp = fieldbus_slave_pkg::RESP_SLVERR;
    end
    if (s_reg.bvalid && bready)
    begin
      s_next.bvalid = 1'b0;
      s_next.awready = 1'b1;
      s_next.wready = 1'b1;
    end

    // axi read: one word, unmapped reads zero with slverr
    if (arvalid && s_reg.arready)
    begin
      s_next.arready = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rresp = fieldbus_slave_pkg::RESP_OKAY;
      s_next.rdata = 32'h0000_0000;
      if (araddr == fieldbus_slave_pkg::CFG_OFFS)
        s_next.rdata = s_reg.cfg;
      else if (araddr == fieldbus_slave_pkg::IOCFG_OFFS)
        s_next.rdata = {16'h0000, s_reg.iocfg};
      else if (araddr == fieldbus_slave_pkg::STATUS_OFFS)
      begin
        s_next.rdata[fieldbus_slave_pkg::ST_SLAVE] = s_reg.slave_active;
        s_next.rdata[fieldbus_slave_pkg::ST_AUX] = s_reg.aux_active;
        s_next.rdata[fieldbus_slave_pkg::ST_AUX_CMOS] = s_reg.aux_cmos;
        s_next.rdata[fieldbus_slave_pkg::ST_NO_EXCH] = s_reg.no_exch;
        s_next.rdata[fieldbus_slave_pkg::ST_HALF_EXP] = s_reg.half_exp;
        s_next.rdata[fieldbus_slave_pkg::ST_DATA_OUT +: 4] = s_reg.data_out;
        s_next.rdata[fieldbus_slave_pkg::ST_SEND +: 4] = s_reg.send_reg;
        s_next.rdata[fieldbus_slave_pkg::ST_ID1 +: 4] = s_reg.id1;
        s_next.rdata[fieldbus_slave_pkg::ST_PARAM +: 4] = s_reg.param_out;
      end
      else
        s_next.rresp = fieldbus_slave_pkg::RESP_SLVERR;
    end
    if (s_reg.rvalid && rready)
    begin
      s_next.rvalid = 1'b0;
      s_next.arready = 1'b1;
    end

    // mode flags are taken once per initialisation; later writes wait for the next one
    if (s_reg.init)
      s_next.slave_active = !s_reg.cfg[fieldbus_slave_pkg::CFG_MASTER_FLAG]
        && !s_reg.cfg[fieldbus_slave_pkg::CFG_REPEATER_FLAG];

    // aux channel: follow whichever input last toggled, cmos wins a tie
    s_next.cmos_q = aux_addressing_input_cmos;
    s_next.photo_q = aux_addressing_input_photo;
    if (aux_addressing_input_cmos != s_reg.cmos_q)
      s_next.aux_cmos = 1'b1;
    else if (aux_addressing_input_photo != s_reg.photo_q)
      s_next.aux_cmos = 1'b0;
    s_next.aux_rx = s_reg.aux_cmos ? s_reg.cmos_q : s_reg.photo_q;
    if (magic_seq_seen && s_reg.slave_active)
      s_next.aux_active = 1'b1;
    s_next.lamp = s_reg.aux_active ? !aux_tx_code : s_reg.no_exch;

    // address tracking and polling cycle measurement
    s_next.cyc_cnt = s_reg.cyc_cnt + 32'h0000_0001;
    if (tel_valid && tel_kind == fieldbus_slave_pkg::KIND_DATA)
      s_next.last_addr = tel_addr;
    if (sync_evt)
    begin
      s_next.cyc_meas = s_reg.cyc_cnt;
      s_next.cyc_cnt = 32'h0000_0000;
    end

    // half-select watchdog, outputs fall to their fixed image on expiry
    if (s_reg.cfg[fieldbus_slave_pkg::CFG_EXT_ADDR] && s_reg.cfg[fieldbus_slave_pkg::CFG_EXT_FOUR_OUT]
      && s_reg.cfg[fieldbus_slave_pkg::CFG_HALF_WD_EN])
    begin
      s_next.half_cnt = s_reg.half_cnt + 32'h0000_0001;
      if (s_reg.half_cnt + 32'h0000_0001 >= 32'(HALF_WD_CYC) && !s_reg.half_exp)
      begin
        s_next.half_exp = 1'b1;
        s_next.data_out = fixed(4'h0, s_reg.iocfg);
      end
    end
    else
      s_next.half_cnt = 32'h0000_0000;

    // communication monitor
    s_next.mon_cnt = s_reg.mon_cnt + 32'h0000_0001;
    if (s_reg.mon_cnt + 32'h0000_0001 >= 32'(COMM_MON_CYC))
    begin
      s_next.mon_cnt = 32'h0000_0000;
      s_next.no_exch = 1'b1;
      if (wd_on)
        s_next.soft_rst = 1'b1;
    end

    // calls addressed to this slave
    if (mine && (tel_kind == fieldbus_slave_pkg::KIND_DATA || tel_kind == fieldbus_slave_pkg::KIND_PARAM))
    begin
      s_next.mon_cnt = 32'h0000_0000;
      s_next.no_exch = 1'b0;
    end
    if (mine && tel_kind == fieldbus_slave_pkg::KIND_DATA)
    begin
      if (tel_info[fieldbus_slave_pkg::HALF_SEL_BIT] != s_reg.prev_half)
      begin
        s_next.half_cnt = 32'h0000_0000;
        s_next.half_exp = 1'b0;
      end
      s_next.prev_half = tel_info[fieldbus_slave_pkg::HALF_SEL_BIT];
      if (sync_on)
      begin
        pend_now = 1'b1;
        pend_val = fixed(next_out(tel_info, s_reg.data_out, s_reg.cfg), s_reg.iocfg);
        s_next.resp_valid = 1'b1;
        s_next.resp_info = s_reg.send_reg;
      end
      else
      begin
        s_next.data_out = fixed(next_out(tel_info, s_reg.data_out, s_reg.cfg), s_reg.iocfg);
        s_next.seq = fieldbus_slave_pkg::DATA_WIN;
        s_next.win_cnt = fieldbus_slave_pkg::STROBE_CYC;
        s_next.data_strobe = 1'b1;
        s_next.data_en = 1'b1;
      end
    end
    if (sync_on && sync_evt && pend_now && s_reg.seq == fieldbus_slave_pkg::IDLE)
    begin
      s_next.data_out = pend_val;
      s_next.pend_valid = 1'b0;
      s_next.seq = fieldbus_slave_pkg::DATA_WIN;
      s_next.win_cnt = fieldbus_slave_pkg::STROBE_CYC;
      s_next.data_strobe = 1'b1;
      s_next.data_en = 1'b1;
    end
    else
    begin
      s_next.pend_valid = pend_now;
      s_next.pend_out = pend_val;
    end
    if (mine && tel_kind == fieldbus_slave_pkg::KIND_PARAM)
    begin
      s_next.param_out = s_reg.cfg[fieldbus_slave_pkg::CFG_EXT_ADDR] ? {s_reg.param_out[3], tel_info[2:0]}
        : tel_info[3:0];
      s_next.seq = fieldbus_slave_pkg::PARAM_WIN;
      s_next.win_cnt = fieldbus_slave_pkg::STROBE_CYC;
      s_next.param_strobe = 1'b1;
      s_next.param_oe_n = 1'b0;
    end
    if (mine && tel_kind == fieldbus_slave_pkg::KIND_ID1)
    begin
      if (!s_reg.cfg[fieldbus_slave_pkg::CFG_ID1_PROTECT])
        s_next.id1 = tel_info[3:0];
      s_next.resp_valid = 1'b1;
      s_next.resp_info = 4'h0;
    end
    if (mine && tel_kind == fieldbus_slave_pkg::KIND_PROG && !s_reg.cfg[fieldbus_slave_pkg::CFG_PROG_LOCK])
      s_next.prog_req = 1'b1;

    // strobe windows: outputs change at the start, inputs are sampled at the end
    unique case (s_reg.seq)
      fieldbus_slave_pkg::IDLE:
      begin
        if (s_next.seq == fieldbus_slave_pkg::IDLE && s_reg.cfg[fieldbus_slave_pkg::CFG_MUX_MODE])
          s_next.data_en = 1'b0;
        else if (s_next.seq == fieldbus_slave_pkg::IDLE)
          s_next.data_en = 1'b1;
      end
      fieldbus_slave_pkg::DATA_WIN:
      begin
        s_next.win_cnt = s_reg.win_cnt - 8'h01;
        if (s_reg.win_cnt == 8'h01)
        begin
          s_next.seq = fieldbus_slave_pkg::IDLE;
          s_next.data_strobe = 1'b0;
          s_next.send_reg = sampled;
          if (!sync_on)
          begin
            s_next.resp_valid = 1'b1;
            s_next.resp_info = sampled;
          end
        end
      end
      fieldbus_slave_pkg::PARAM_WIN:
      begin
        s_next.win_cnt = s_reg.win_cnt - 8'h01;
        // the bidirectional port lets go after the first five cycles, for the last three, for the outside to answer
        if (s_reg.cfg[fieldbus_slave_pkg::CFG_BIDIR_PARAM] && s_reg.win_cnt <= (fieldbus_slave_pkg::STROBE_CYC >> 1))
          s_next.param_oe_n = 1'b1;
        if (s_reg.win_cnt == 8'h01)
        begin
          s_next.seq = fieldbus_slave_pkg::IDLE;
          s_next.param_strobe = 1'b0;
          s_next.param_oe_n = 1'b0;
          s_next.resp_valid = 1'b1;
          s_next.resp_info = s_reg.cfg[fieldbus_slave_pkg::CFG_BIDIR_PARAM] ? param_in : s_reg.param_out;
        end
      end
    endcase

    // watchdog reset restarts everything but the configuration, the axi channel state and, if kept, the aux mode
    if (s_reg.soft_rst)
    begin
      s_next = reset_state();
      s_next.cfg = s_reg.cfg;
      s_next.iocfg = s_reg.iocfg;
      s_next.aux_active = s_reg.aux_active && s_reg.cfg[fieldbus_slave_pkg::CFG_AUX_KEEP];
      s_next.awready = s_reg.awready;
      s_next.wready = s_reg.wready;
      s_next.awaddr = s_reg.awaddr;
      s_next.wdata = s_reg.wdata;
      s_next.wstrb = s_reg.wstrb;
      s_next.bvalid = s_reg.bvalid;
      s_next.bresp = s_reg.bresp;
      s_next.arready = s_reg.arready;
      s_next.rvalid = s_reg.rvalid;
      s_next.rdata = s_reg.rdata;
      s_next.rresp = s_reg.rresp;
    end
  end

  // state register; the ic reset also drops aux mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_reg <= reset_state();
    else
      s_reg <= s_next;
  end

  // outputs straight from the state register
  assign awready = s_reg.awready;
  assign wready = s_reg.wready;
  assign bvalid = s_reg.bvalid;
  assign bresp = s_reg.bresp;
  assign arready = s_reg.arready;
  assign rvalid = s_reg.rvalid;
  assign rdata = s_reg.rdata;
  assign rresp = s_reg.rresp;
  assign resp_valid = s_reg.resp_valid;
  assign resp_info = s_reg.resp_info;
  assign prog_mode_req = s_reg.prog_req;
  assign aux_rx_data = s_reg.aux_rx;
  assign status_lamp_one = s_reg.lamp;
  assign data_out = s_reg.data_out;
  assign data_out_en = s_reg.data_en;
  assign data_strobe = s_reg.data_strobe;
  assign param_out = s_reg.param_out;
  assign param_oe_n = s_reg.param_oe_n;
  assign param_strobe = s_reg.param_strobe;
endmodule

// ==== core/fieldbus_slave_pkg.sv ====
// fieldbus slave processing: register map, field positions, call kinds and timing constants
// assumes a 250 MHz system clock; all counts but STROBE_CYC are derived from the times below
package fieldbus_slave_pkg;
  // clock
  localparam int CLK_PERIOD_PS = 4000;
  // register byte offsets
  localparam logic [7:0] CFG_OFFS = 8'h00;
  localparam logic [7:0] IOCFG_OFFS = 8'h04;
  localparam logic [7:0] STATUS_OFFS = 8'h08;
  // configuration register fields
  localparam int CFG_MASTER_FLAG = 0;
  localparam int CFG_REPEATER_FLAG = 1;
  localparam int CFG_BIDIR_PARAM = 2;
  localparam int CFG_MUX_MODE = 3;
  localparam int CFG_INVERT_ALL = 4;
  localparam int CFG_FILTER_EN = 5;
  localparam int CFG_FILTER_P2 = 6;
  localparam int CFG_CYCLE_MODE = 7;
  localparam int CFG_SYNC_MODE = 8;
  localparam int CFG_EXT_ADDR = 9;
  localparam int CFG_EXT_FOUR_OUT = 10;
  localparam int CFG_HALF_WD_EN = 11;
  localparam int CFG_SAFETY = 12;
  localparam int CFG_COMM_WD_EN = 13;
  localparam int CFG_COMM_WD_P0 = 14;
  localparam int CFG_PROG_LOCK = 15;
  localparam int CFG_ID1_PROTECT = 16;
  localparam int CFG_AUX_KEEP = 17;
  localparam int CFG_FILTER_SEL = 18;
  localparam int CFG_FILTER_SEL_W = 3;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  // io configuration register fields
  localparam int IOCFG_INVERT = 0;
  localparam int IOCFG_FILTER = 4;
  localparam int IOCFG_FIXED_MASK = 8;
  localparam int IOCFG_FIXED_LEVEL = 12;
  localparam logic [15:0] IOCFG_RESET = 16'h0000;
  // status register fields
  localparam int ST_SLAVE = 0;
  localparam int ST_AUX = 1;
  localparam int ST_AUX_CMOS = 2;
  localparam int ST_NO_EXCH = 3;
  localparam int ST_HALF_EXP = 4;
  localparam int ST_DATA_OUT = 8;
  localparam int ST_SEND = 12;
  localparam int ST_ID1 = 16;
  localparam int ST_PARAM = 20;
  // call kinds decoded upstream
  localparam logic [2:0] KIND_DATA = 3'h0;
  localparam logic [2:0] KIND_PARAM = 3'h1;
  localparam logic [2:0] KIND_ID1 = 3'h2;
  localparam logic [2:0] KIND_PROG = 3'h3;
  // request bit positions
  localparam int HALF_SEL_BIT = 2;
  localparam int REQ_BIT_THREE = 3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // times, then cycle counts
  localparam longint FILTER_BASE_NS = 128000;
  localparam longint HALF_WD_NS = 327000000;
  localparam longint COMM_MON_NS = 41000000;
  localparam int FILTER_BASE_CYC = int'(FILTER_BASE_NS * 1000 / CLK_PERIOD_PS);
  localparam int HALF_WD_CYC = int'(HALF_WD_NS * 1000 / CLK_PERIOD_PS);
  localparam int COMM_MON_CYC = int'(COMM_MON_NS * 1000 / CLK_PERIOD_PS);
  localparam logic [7:0] STROBE_CYC = 8'h08;
  // port sequencer states
  typedef enum logic [1:0] {IDLE, DATA_WIN, PARAM_WIN} seq_t;
endpackage

// ==== core/input_debounce.sv ====
// per-bit debounce filter for the data inputs
// assumes raw inputs are synchronous to aclk; duration is held steady by the caller
`timescale 1ns/100ps
module input_debounce #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic rst_n,
  // control
  input wire logic [W-1:0] enable,
  input wire logic [31:0] duration,
  // data
  input wire logic [W-1:0] raw,
  output logic [W-1:0] filt
);
  typedef struct packed {
    logic [W-1:0] level;
    logic [W-1:0][31:0] cnt;
  } deb_t;
  deb_t deb_reg;
  deb_t deb_next;

  // an enabled bit follows its raw level only after it has differed for the whole duration
  always_comb
  begin
    deb_next = deb_reg;
    for (int i = 0; i < W; i++)
    begin
      if (!enable[i] || raw[i] == deb_reg.level[i])
      begin
        deb_next.cnt[i] = 32'h0000_0000;
        deb_next.level[i] = raw[i];
      end
      else if (deb_reg.cnt[i] + 32'h0000_0001 >= duration)
      begin
        deb_next.cnt[i] = 32'h0000_0000;
        deb_next.level[i] = raw[i];
      end
      else
        deb_next.cnt[i] = deb_reg.cnt[i] + 32'h0000_0001;
    end
  end

  // state register
  always_ff @(posedge aclk)
  begin
    if (!rst_n)
      deb_reg <= '0;
    else
      deb_reg <= deb_next;
  end

  assign filt = deb_reg.level;
endmodule

// ==== bench/fieldbus_slave_sva.sv ====
// checker: window and bus timing at the fieldbus slave ports
// assumes one clock domain; bound to every fieldbus_slave
`timescale 1ns/100ps
module fieldbus_slave_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // port sequencer outputs
  input wire logic data_strobe,
  input wire logic param_strobe,
  input wire logic [3:0] data_out,
  input wire logic data_out_en,
  input wire logic param_oe_n,
  input wire logic prog_mode_req,
  // read channel
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // a strobe window lasts exactly eight cycles
  sequence win_s(s);
    s[*8] ##1 !s;
  endsequence
  a_data_win: assert property ($rose(data_strobe) |-> win_s(data_strobe)) else $error("data strobe length");
  a_data_stable: assert property ($rose(data_strobe) |=> $stable(data_out)[*7]) else $error("data out moved");
  a_mux_window: assert property (data_strobe |-> data_out_en) else $error("outputs off in window");
  a_param_win: assert property ($rose(param_strobe) |-> win_s(param_strobe)) else $error("param strobe length");
  a_one_window: assert property (!(data_strobe && param_strobe)) else $error("two windows at once");
  a_param_idle: assert property (!param_strobe |-> !param_oe_n) else $error("param pins released");
  a_prog_pulse: assert property (prog_mode_req |=> !prog_mode_req) else $error("program request too long");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready) else $error("read not answered");
endmodule

bind fieldbus_slave fieldbus_slave_sva i_sva (.aclk(aclk), .aresetn(aresetn), .data_strobe(data_strobe),
  .param_strobe(param_strobe), .data_out(data_out), .data_out_en(data_out_en), .param_oe_n(param_oe_n),
  .prog_mode_req(prog_mode_req), .arvalid(arvalid), .arready(arready), .rvalid(rvalid));

// ==== bench/io_partner.sv ====
// external i/o logic on the data and parameter pins
// assumes the bench picks the values presented
`timescale 1ns/100ps
module io_partner (
  // device side
  input wire logic data_strobe,
  input wire logic param_oe_n,
  input wire logic [3:0] param_out,
  // values offered
  input wire logic [3:0] in_val,
  input wire logic [3:0] par_val,
  // pin levels
  output logic [3:0] data_in,
  output logic [3:0] param_in
);
  // fresh inputs only inside the strobe window, stale pattern outside
  assign data_in = data_strobe ? in_val : ~in_val;
  // shared pins: the device wins while it drives
  assign param_in = param_oe_n ? par_val : param_out;
endmodule

// ==== bench/tb_top.sv ====
// testbench: data, parameter, monitor and aux behaviour
// assumes short watchdog times; partner drives the pins
`timescale 1ns/100ps
module tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, tel_valid, tel_to_me, magic;
  logic awready, wready, bvalid, arready, rvalid, resp_valid, prog_mode_req, status_lamp_one;
  logic data_out_en, data_strobe, param_oe_n, param_strobe;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb, in_val, par_val, data_in, param_in, data_out, resp_info, param_out;
  logic [2:0] tel_kind;
  logic [4:0] tel_addr, tel_info;
  logic [1:0] bresp, rresp, rs;
  int n_fail, n_tests, cyc, n_prog;
  fieldbus_slave #(.FILTER_BASE_CYC(8), .HALF_WD_CYC(200), .COMM_MON_CYC(300)) i_fieldbus_slave (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .tel_valid(tel_valid), .tel_kind(tel_kind), .tel_addr(tel_addr), .tel_info(tel_info),
    .tel_to_me(tel_to_me), .resp_valid(resp_valid), .resp_info(resp_info), .prog_mode_req(prog_mode_req),
    .aux_addressing_input_cmos(1'h0), .aux_addressing_input_photo(1'h0), .magic_seq_seen(magic),
    .aux_tx_code(in_val[0]), .aux_rx_data(), .status_lamp_one(status_lamp_one), .data_in(data_in),
    .data_out(data_out), .data_out_en(data_out_en), .data_strobe(data_strobe), .param_in(param_in),
    .param_out(param_out), .param_oe_n(param_oe_n), .param_strobe(param_strobe));
  io_partner i_io_partner (.data_strobe(data_strobe), .param_oe_n(param_oe_n), .param_out(param_out),
    .in_val(in_val), .par_val(par_val), .data_in(data_in), .param_in(param_in));
  initial
  begin
    aclk = 1'h0;
    forever #2 aclk = ~aclk;
  end
  // hang guard, program pulse count
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (prog_mode_req === 1'h1)
      n_prog <= n_prog + 1;
    if (cyc == 5000)
    begin
      n_fail++;
      report_and_stop;
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // write: aw and w together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'h7;
    do
    begin
      @(posedge aclk);
      if (awready)
        awvalid <= 1'h0;
      if (wready)
        wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    rs = bresp;
    bready <= 1'h0;
  endtask
  task automatic rdreg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do
    begin
      @(posedge aclk);
      if (arready)
        arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rd = rdata;
    rs = rresp;
    rready <= 1'h0;
  endtask
  // one call, then wait out the window
  task automatic tel(input logic [2:0] k, input logic [4:0] i);
    @(posedge aclk);
    tel_valid <= 1'h1;
    tel_kind <= k;
    tel_info <= i;
    @(posedge aclk);
    tel_valid <= 1'h0;
    repeat (11) @(posedge aclk);
  endtask
  task automatic t_bus;
    rdreg(8'h08);
    chk("slave", 32'h1, rd[0]);
    rdreg(8'h0C);
    chk("unmapped", 32'h2, rs);
    wr(8'h08, 32'hF);
    chk("ro write", 32'h2, rs);
  endtask
  task automatic t_data;
    in_val <= 4'hA;
    tel(3'h0, 5'h05);
    chk("out", 32'h5, data_out);
    chk("send", 32'hA, resp_info);
    wr(8'h04, 32'h3);
    tel(3'h0, 5'h05);
    chk("inv bits", 32'h9, resp_info);
    wr(8'h04, 32'h100);
    wr(8'h00, 32'h18);
    tel(3'h0, 5'h0F);
    chk("fixed", 32'hE, data_out);
    chk("inv all", 32'h5, resp_info);
    chk("mux idle", 32'h0, data_out_en);
    wr(8'h04, 32'h0);
    wr(8'h00, 32'h0);
  endtask
  task automatic t_ext;
    tel(3'h0, 5'h00);
    wr(8'h00, 32'h600);
    tel(3'h0, 5'h06);
    chk("upper half", 32'h8, data_out);
    tel(3'h0, 5'h01);
    chk("lower half", 32'h9, data_out);
    wr(8'h00, 32'h200);
    tel(3'h0, 5'h00);
    chk("ab select", 32'h8, data_out);
    wr(8'h00, 32'h0);
    tel(3'h0, 5'h07);
    chk("bit three", 32'h7, data_out);
  endtask
  task automatic t_param;
    tel(3'h1, 5'h06);
    chk("param out", 32'h6, param_out);
    chk("param echo", 32'h6, resp_info);
    wr(8'h00, 32'h4);
    par_val <= 4'h9;
    tel(3'h1, 5'h03);
    chk("param in", 32'h9, resp_info);
    wr(8'h00, 32'h0);
  endtask
  task automatic t_prog;
    tel(3'h3, 5'h00);
    chk("prog", 32'h1, n_prog);
    wr(8'h00, 32'h8000);
    tel(3'h3, 5'h00);
    chk("prog locked", 32'h1, n_prog);
  endtask
  task automatic t_mon;
    repeat (320) @(posedge aclk);
    rdreg(8'h08);
    chk("no exch", 32'h1, rd[3]);
    chk("lamp", 32'h1, status_lamp_one);
    tel(3'h0, 5'h00);
    magic <= 1'h1;
    rdreg(8'h08);
    chk("exch back", 32'h0, rd[3]);
    chk("aux", 32'h1, rd[1]);
    chk("aux lamp", 32'h1, status_lamp_one);
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, tel_valid, magic} = 8'h0;
    {awaddr, araddr, wdata, tel_kind, tel_info, in_val, par_val} = '0;
    {wstrb, tel_to_me, tel_addr} = 10'h3E1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    t_bus;
    t_data;
    t_ext;
    t_param;
    t_prog;
    t_mon;
    report_and_stop;
  end
endmodule
